// ===== core/nro_alu.sv
// Nibble ALU for OR and rotate through carry.
`timescale 1ns/10ps
`default_nettype none
module nro_alu (
   // ALU operands and results
   nro_alu_if.alu bus
);
   import nro_pkg::*;

   always_comb begin
      bus.res  = bus.opa | bus.opb;
      bus.cout = bus.cin;
      unique case (bus.op)
         NRO_OP_OR: begin
            bus.res  = bus.opa | bus.opb;
            bus.cout = bus.cin;
         end
         NRO_OP_RLC: begin
            bus.res  = {bus.opa[NRO_NIB_W-2:0], bus.cin};
            bus.cout = bus.opa[NRO_NIB_W-1];
         end
         NRO_OP_RRC: begin
            bus.res  = {bus.cin, bus.opa[NRO_NIB_W-1:1]};
            bus.cout = bus.opa[0];
         end
         default: begin
            bus.res  = bus.opa | bus.opb;
            bus.cout = bus.cin;
         end
      endcase
   end

   assign bus.zero = (bus.res == NRO_NIB_ZERO);

endmodule
`default_nettype wire

// ===== core/nro_core.sv
// Execution datapath for the OR and rotate-through-carry instructions.
`timescale 1ns/10ps
`default_nettype none
module nro_core (
   // Clock and reset
   input  wire logic                              sys_clk_i,
   input  wire logic                              rstn_i,
   // Instruction from the decoder
   input  wire logic                              exec_i,
   input  wire logic [nro_pkg::NRO_INSTR_W-1:0]   instr_i,
   // Preload of memory, accumulator and carry (ignored while exec_i is high)
   input  wire logic                              mem_we_i,
   input  wire logic [nro_pkg::NRO_ADDR_W-1:0]    mem_addr_i,
   input  wire logic [nro_pkg::NRO_NIB_W-1:0]     mem_data_i,
   input  wire logic                              acc_we_i,
   input  wire logic [nro_pkg::NRO_NIB_W-1:0]     acc_data_i,
   input  wire logic                              carry_we_i,
   input  wire logic                              carry_data_i,
   // Memory read-back
   input  wire logic [nro_pkg::NRO_ADDR_W-1:0]    rd_addr_i,
   output logic      [nro_pkg::NRO_NIB_W-1:0]     rd_data_o,
   // Core state
   output logic      [nro_pkg::NRO_NIB_W-1:0]     acc_o,
   output logic                                   carry_flag_o,
   output logic                                   zero_flag_o,
   output logic                                   done_o,
   output logic                                   bad_op_o
);
   import nro_pkg::*;

   // **********************************************************************
   // Decode.
   // **********************************************************************
   wire logic [8:0]            pfx9 = instr_i[NRO_PFX9_LSB +: 9];
   wire logic [7:0]            pfx8 = instr_i[NRO_PFX8_LSB +: 8];
   wire logic [NRO_ADDR_W-1:0] maddr = instr_i[NRO_ADDR_LSB +: NRO_ADDR_W];
   wire logic [NRO_NIB_W-1:0]  imm = instr_i[NRO_IMM_LSB +: NRO_NIB_W];
   wire logic [NRO_WSEL_W-1:0] wsel = instr_i[NRO_WSEL_LSB +: NRO_WSEL_W];

   // Every strobe is qualified by exec_i, so a stale word on instr_i does nothing.
   wire logic is_or_mem  = exec_i && (pfx9 == NRO_OPC_OR_MEM);
   wire logic is_or_imm  = exec_i && (pfx8 == NRO_OPC_OR_IMM);
   wire logic is_orw_mem = exec_i && (pfx9 == NRO_OPC_ORW_MEM);
   wire logic is_orw_imm = exec_i && (pfx8 == NRO_OPC_ORW_IMM);
   wire logic is_rlc     = exec_i && (pfx9 == NRO_OPC_RLC);
   wire logic is_rrc     = exec_i && (pfx9 == NRO_OPC_RRC);

   wire logic use_imm = is_or_imm || is_orw_imm;
   wire logic is_rot  = is_rlc || is_rrc;
   wire logic is_or   = is_or_mem || is_or_imm || is_orw_mem || is_orw_imm;
   wire logic any_op  = is_or || is_rot;
   wire logic wback   = is_orw_mem || is_orw_imm || is_rot;

   // Immediate forms read a working register; the others read the addressed nibble.
   wire logic [NRO_ADDR_W-1:0] wr_addr =
      NRO_ADDR_W'(NRO_WR_BASE + {{(NRO_ADDR_W-NRO_WSEL_W){1'b0}}, wsel});
   wire logic [NRO_ADDR_W-1:0] src_addr = use_imm ? wr_addr : maddr;

   // **********************************************************************
   // State.
   // **********************************************************************
   logic [NRO_NIB_W-1:0] mem_q [NRO_MEM_WORDS];
   logic [NRO_NIB_W-1:0] acc_q;
   logic [NRO_NIB_W-1:0] acc_d;
   logic                 carry_q;
   logic                 carry_d;
   logic                 zero_q;
   logic [NRO_NIB_W-1:0] rd_q;
   logic                 done_q;
   logic                 bad_q;

   wire logic [NRO_NIB_W-1:0] src_nib = mem_q[src_addr];

   // **********************************************************************
   // ALU.
   // **********************************************************************
   nro_alu_if alu_bus ();

   // Rotates take the nibble in opa; opb only matters for the OR forms.
   assign alu_bus.op  = is_rlc ? NRO_OP_RLC : (is_rrc ? NRO_OP_RRC : NRO_OP_OR);
   assign alu_bus.opa = src_nib;
   assign alu_bus.opb = use_imm ? imm : acc_q;
   assign alu_bus.cin = carry_q;

   nro_alu u_alu (
      .bus (alu_bus)
   );

   // Execute wins over a preload given in the same cycle.
   assign acc_d   = any_op ? alu_bus.res
                  : ((!exec_i && acc_we_i) ? acc_data_i : acc_q);
   assign carry_d = is_rot ? alu_bus.cout
                  : ((!exec_i && carry_we_i) ? carry_data_i : carry_q);

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         acc_q   <= NRO_NIB_ZERO;
         carry_q <= 1'b0;
      end else begin
         acc_q   <= acc_d;
         carry_q <= carry_d;
      end
   end

   // The zero flag follows only the six instructions; preloads leave it alone.
   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         zero_q <= 1'b0;
      end else if (any_op) begin
         zero_q <= alu_bus.zero;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         rd_q   <= NRO_NIB_ZERO;
         done_q <= 1'b0;
         bad_q  <= 1'b0;
      end else begin
         rd_q   <= mem_q[rd_addr_i];
         done_q <= any_op;
         bad_q  <= exec_i && !any_op;
      end
   end

   // Data memory holds no reset; software initialises it.
   always_ff @(posedge sys_clk_i) begin
      if (wback) begin
         mem_q[src_addr] <= alu_bus.res;
      end else if (!exec_i && mem_we_i) begin
         mem_q[mem_addr_i] <= mem_data_i;
      end
   end

   assign acc_o        = acc_q;
   assign carry_flag_o = carry_q;
   assign zero_flag_o  = zero_q;
   assign rd_data_o    = rd_q;
   assign done_o       = done_q;
   assign bad_op_o     = bad_q;

   // **********************************************************************
   // Checks.
   // **********************************************************************
   chk_or_mem_acc: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_or_mem |=> acc_q == ($past(src_nib) | $past(acc_q)) && done_q)
      else $error("OR memory result wrong in accumulator.");

   chk_or_mem_keep: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_or_mem |=> mem_q[$past(src_addr)] == $past(src_nib))
      else $error("OR memory changed the memory nibble.");

   chk_or_imm_acc: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_or_imm |=> acc_q == ($past(src_nib) | $past(imm))
                    && mem_q[$past(src_addr)] == $past(src_nib))
      else $error("OR immediate result wrong or register changed.");

   chk_orw_mem_both: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_orw_mem |=> acc_q == ($past(src_nib) | $past(acc_q))
                     && mem_q[$past(src_addr)] == acc_q)
      else $error("OR memory writeback mismatch.");

   chk_orw_imm_both: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_orw_imm |=> acc_q == ($past(src_nib) | $past(imm))
                     && mem_q[$past(src_addr)] == acc_q && done_q)
      else $error("OR immediate writeback mismatch.");

   chk_rlc_value: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_rlc |=> {carry_q, acc_q} == {$past(src_nib), $past(carry_q)}
                 && mem_q[$past(src_addr)] == acc_q)
      else $error("Rotate left result wrong.");

   chk_rrc_value: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_rrc |=> {acc_q, carry_q} == {$past(carry_q), $past(src_nib)}
                 && mem_q[$past(src_addr)] == acc_q)
      else $error("Rotate right result wrong.");

   chk_rot_one_cycle: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_rot |=> done_q && !bad_q && zero_q == (acc_q == NRO_NIB_ZERO))
      else $error("Rotate not finished in one cycle with zero flag.");

   chk_zero_flag: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      done_q |-> zero_q == (acc_q == NRO_NIB_ZERO))
      else $error("Zero flag does not match result.");

   chk_or_carry_keep: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      is_or |=> carry_q == $past(carry_q))
      else $error("OR instruction changed the carry flag.");

   chk_bad_op_quiet: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      exec_i && !any_op |=> bad_q && !done_q && acc_q == $past(acc_q)
                            && carry_q == $past(carry_q) && zero_q == $past(zero_q))
      else $error("Unknown opcode changed the core state.");

   chk_exec_drops_load: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      exec_i && mem_we_i && !wback |=> mem_q[$past(mem_addr_i)] == $past(mem_q[mem_addr_i]))
      else $error("Memory preload taken while an instruction ran.");

   // **********************************************************************
   // Preload and reset checks.
   // **********************************************************************
   chk_preload_acc: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !exec_i && acc_we_i |=> acc_q == $past(acc_data_i))
      else $error("Accumulator preload not taken.");

   chk_preload_carry: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !exec_i && carry_we_i |=> carry_q == $past(carry_data_i))
      else $error("Carry preload not taken.");

   chk_preload_mem: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !exec_i && mem_we_i |=> mem_q[$past(mem_addr_i)] == $past(mem_data_i))
      else $error("Memory preload not taken.");

   chk_reset_state: assert property (@(posedge sys_clk_i)
      !rstn_i |=> acc_q == NRO_NIB_ZERO && !carry_q && !zero_q && rd_q == NRO_NIB_ZERO
                  && !done_q && !bad_q)
      else $error("Core state not cleared by reset.");

endmodule
`default_nettype wire

// ===== pkg/nro_alu_if.sv
// Interface between the datapath control and its nibble ALU.
`timescale 1ns/10ps
`default_nettype none
interface nro_alu_if;
   import nro_pkg::*;
   nro_op_t              op;
   logic [NRO_NIB_W-1:0] opa;
   logic [NRO_NIB_W-1:0] opb;
   logic                 cin;
   logic [NRO_NIB_W-1:0] res;
   logic                 cout;
   logic                 zero;

   modport alu  (input op, opa, opb, cin, output res, cout, zero);
   modport ctrl (output op, opa, opb, cin, input res, cout, zero);
endinterface
`default_nettype wire

// ===== pkg/nro_pkg.sv
// Constants and types shared by the nibble OR and rotate datapath.
package nro_pkg;

   localparam int NRO_NIB_W   = 4;
   localparam int NRO_ADDR_W  = 7;
   localparam int NRO_INSTR_W = 16;
   localparam int NRO_WSEL_W  = 4;
   localparam int NRO_MEM_WORDS = 128;

   // **********************************************************************
   // Instruction fields.
   // **********************************************************************
   localparam int NRO_PFX9_LSB = 7;
   localparam int NRO_PFX8_LSB = 8;
   localparam int NRO_IMM_LSB  = 4;
   localparam int NRO_WSEL_LSB = 0;
   localparam int NRO_ADDR_LSB = 0;

   // **********************************************************************
   // Opcode prefixes.
   // **********************************************************************
   localparam logic [8:0] NRO_OPC_OR_MEM  = 9'h074;
   localparam logic [8:0] NRO_OPC_ORW_MEM = 9'h076;
   localparam logic [8:0] NRO_OPC_RLC     = 9'h099;
   localparam logic [8:0] NRO_OPC_RRC     = 9'h09b;
   localparam logic [7:0] NRO_OPC_OR_IMM  = 8'h3e;
   localparam logic [7:0] NRO_OPC_ORW_IMM = 8'h3f;

   // Working registers occupy the bottom of data memory.
   localparam logic [NRO_ADDR_W-1:0] NRO_WR_BASE = 7'h00;

   localparam logic [NRO_NIB_W-1:0] NRO_NIB_ZERO = 4'h0;

   typedef enum logic [2:0] {
      NRO_OP_OR  = 3'b001,
      NRO_OP_RLC = 3'b010,
      NRO_OP_RRC = 3'b100
   } nro_op_t;

endpackage

// ===== tb/nibble_or_rotate_ops_tb.sv
// Self-checking testbench for the nibble OR and rotate datapath.
`timescale 1ns/10ps
`default_nettype none
module nibble_or_rotate_ops_tb;
   import nro_pkg::*;
   logic                   sys_clk_i = 1'b0;
   logic                   rstn_i = 1'b0;
   logic                   exec_i = 1'b0;
   logic [NRO_INSTR_W-1:0] instr_i = '0;
   logic                   mem_we_i = 1'b0;
   logic [NRO_ADDR_W-1:0]  mem_addr_i = '0;
   logic [NRO_NIB_W-1:0]   mem_data_i = '0;
   logic                   acc_we_i = 1'b0;
   logic [NRO_NIB_W-1:0]   acc_data_i = '0;
   logic                   carry_we_i = 1'b0;
   logic                   carry_data_i = 1'b0;
   logic [NRO_ADDR_W-1:0]  rd_addr_i = '0;
   logic [NRO_NIB_W-1:0]   rd_data_o, acc_o;
   logic                   carry_flag_o, zero_flag_o, done_o, bad_op_o;
   int                     err_count = 0;
   int                     cmp_count = 0;

   nro_core DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .exec_i(exec_i), .instr_i(instr_i),
      .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_data_i(mem_data_i),
      .acc_we_i(acc_we_i), .acc_data_i(acc_data_i), .carry_we_i(carry_we_i),
      .carry_data_i(carry_data_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
      .acc_o(acc_o), .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o),
      .done_o(done_o), .bad_op_o(bad_op_o));

   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // ******************************************************************
   // Compare, preload, execute and read-back tasks.
   // ******************************************************************
   task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Drives every input except the clock and rstn_i once, just after an edge, and lets one edge take them.
   task automatic step(input logic x, input logic [15:0] ins, input logic we,
                       input logic [6:0] a, input logic [3:0] d, input logic [3:0] ac,
                       input logic c);
      exec_i = x;
      instr_i = ins;
      mem_we_i = we;
      acc_we_i = we;
      carry_we_i = we;
      mem_addr_i = a;
      rd_addr_i = a;
      mem_data_i = d;
      acc_data_i = ac;
      carry_data_i = c;
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic pre(input logic [6:0] a, input logic [3:0] d, input logic [3:0] ac,
                      input logic c);
      step(1'b0, '0, 1'b1, a, d, ac, c);
   endtask

   // Runs one instruction and checks the state it leaves after its single edge.
   task automatic run(input logic [15:0] ins, input logic [3:0] ea, input logic ec,
                      input logic ez);
      step(1'b1, ins, 1'b0, '0, '0, '0, 1'b0);
      chk1("done_o", 1'b1, done_o);
      chk1("bad_op_o", 1'b0, bad_op_o);
      chk4("acc_o", ea, acc_o);
      chk1("carry_flag_o", ec, carry_flag_o);
      chk1("zero_flag_o", ez, zero_flag_o);
   endtask

   task automatic rd(input logic [6:0] a, input logic [3:0] e);
      step(1'b0, '0, 1'b0, a, '0, '0, 1'b0);
      chk4("rd_data_o", e, rd_data_o);
   endtask

   // ******************************************************************
   // Scenarios.
   // ******************************************************************
   task automatic t_reset;
      chk4("acc_o", 4'h0, acc_o);
      chk1("carry_flag_o", 1'b0, carry_flag_o);
      chk1("zero_flag_o", 1'b0, zero_flag_o);
      chk1("done_o", 1'b0, done_o);
      chk1("bad_op_o", 1'b0, bad_op_o);
      chk4("rd_data_o", 4'h0, rd_data_o);
   endtask

   // A reset in mid-run clears the core state but keeps data memory.
   task automatic t_mid_reset;
      pre(7'h30, 4'hc, 4'h9, 1'b1);
      rstn_i = 1'b0;
      step(1'b0, '0, 1'b0, 7'h30, '0, '0, 1'b0);
      t_reset();
      rstn_i = 1'b1;
      rd(7'h30, 4'hc);
   endtask

   task automatic t_or_mem;
      pre(7'h45, 4'h5, 4'ha, 1'b1);
      run({NRO_OPC_OR_MEM, 7'h45}, 4'hf, 1'b1, 1'b0);
      rd(7'h45, 4'h5);
      pre(7'h46, 4'h0, 4'h0, 1'b0);
      run({NRO_OPC_OR_MEM, 7'h46}, 4'h0, 1'b0, 1'b1);
   endtask

   task automatic t_or_imm;
      pre(7'h03, 4'h8, 4'h0, 1'b1);
      run({NRO_OPC_OR_IMM, 4'h1, 4'h3}, 4'h9, 1'b1, 1'b0);
      rd(7'h03, 4'h8);
   endtask

   task automatic t_orw_mem;
      pre(7'h7f, 4'h2, 4'h4, 1'b0);
      run({NRO_OPC_ORW_MEM, 7'h7f}, 4'h6, 1'b0, 1'b0);
      rd(7'h7f, 4'h6);
   endtask

   task automatic t_orw_imm;
      pre(7'h0f, 4'h0, 4'h5, 1'b1);
      run({NRO_OPC_ORW_IMM, 4'h0, 4'hf}, 4'h0, 1'b1, 1'b1);
      pre(7'h0e, 4'h4, 4'h0, 1'b0);
      run({NRO_OPC_ORW_IMM, 4'h3, 4'he}, 4'h7, 1'b0, 1'b0);
      rd(7'h0e, 4'h7);
   endtask

   // Two rotates back to back check the result feeds the next instruction.
   task automatic t_rotate;
      pre(7'h05, 4'h9, 4'h0, 1'b0);
      run({NRO_OPC_RLC, 7'h05}, 4'h2, 1'b1, 1'b0);
      run({NRO_OPC_RLC, 7'h05}, 4'h5, 1'b0, 1'b0);
      rd(7'h05, 4'h5);
      pre(7'h10, 4'h1, 4'h0, 1'b0);
      run({NRO_OPC_RRC, 7'h10}, 4'h0, 1'b1, 1'b1);
      run({NRO_OPC_RRC, 7'h10}, 4'h8, 1'b0, 1'b0);
      rd(7'h10, 4'h8);
   endtask

   // Unknown opcode with competing preloads must change nothing.
   task automatic t_bad_op;
      pre(7'h20, 4'h3, 4'h7, 1'b1);
      step(1'b1, 16'hffff, 1'b1, 7'h20, 4'h0, 4'h0, 1'b0);
      chk1("bad_op_o", 1'b1, bad_op_o);
      chk1("done_o", 1'b0, done_o);
      chk4("acc_o", 4'h7, acc_o);
      chk1("carry_flag_o", 1'b1, carry_flag_o);
      rd(7'h20, 4'h3);
   endtask

   task automatic print_verdict;
      if (err_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #20000;
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge sys_clk_i);
      #1 t_reset();
      rstn_i = 1'b1;
      t_or_mem();
      t_or_imm();
      t_orw_mem();
      t_orw_imm();
      t_rotate();
      t_mid_reset();
      t_bad_op();
      print_verdict();
   end
endmodule
`default_nettype wire
